// ==== logic/nfh_host_ctrl.sv ====
// nfh_host_ctrl: ahb-lite controlled host that drives a nand flash over its pins
//
// Contract
// (RL1) with chip select high the flash ignores strobes and floats its bus
// (RL2) with chip select low each write pulse takes a byte, read pulse drives one
// (RL3) cle selects command, ale address, neither data; never both together
// (RL4) a page and the flash data register hold 528 bytes
// (RL5) a block is 32 pages; erase works on whole blocks
// (RL6) each command is exactly one byte into the command register
// (RL7) address phase sends column byte first, then row bytes
// (RL8) all commands but read-status take an address phase; read-status none; code only refuses an address on read-status, others may have none
// (RL9) after read command and address, data read only once ready returns
// (RL10) page read starts with byte 00h under cle, taken at write rise
// (RL11) flash reads out a page at 50 ns per byte
// (RL12) program busy about 200 us, block erase about 2 ms
// (RL13) host multiplexes address and data on 16 bits, 8 or 16 bit devices
// (RL14) host words are 32 bits: four bytes or two halfwords each
// (RL15) no unpacked mode: every external access belongs to a packed word
// (RL16) host address-latch output polarity is programmable high or low
// (RL17) host takes read data at read strobe rise; devices take writes at write rise
// (RL18) ready/busy stays low during any array operation, high when done
// (RL19) first row byte: low five bits page, top three bits start block
// (RL20) program: 80h, address, data bytes, confirm; then flash goes busy
// (RL21) erase: 60h, block address only, d0h; busy until erase done
// (RL22) bytes written with both latch enables high are discarded by flash
// (RL23) no command but read-status while busy; wait for ready first
module nfh_host_ctrl #(
    parameter int         BUSY_LIMIT = nfh_pkg::BUSY_LIM_CYC,
    parameter logic [7:0] STATUS_CMD = 8'h70
) (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    output logic             ce_n_o,
    output logic             cle_o,
    output logic             ale_o,
    output logic             we_n_o,
    output logic             read_strobe_n_o,
    output logic      [15:0] ad_o,
    output logic             ad_oe_o,
    input  wire logic [15:0] ad_i,
    input  wire logic        rb_i
);
    import nfh_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic        dp_ff;
    logic        dp_wr_ff;
    logic [7:0]  dp_adr_ff;
    logic        hready_ff;
    logic        hresp_ff;
    logic [31:0] hrdata_ff;
    logic [2:0]  ctrl_ff;
    logic [11:0] cmd_ff;
    logic [31:0] addr_ff;
    logic [31:0] wdata_ff;
    logic [31:0] pack_ff;
    logic        rd_ff;
    logic [3:0]  err_ff;
    logic [9:0]  cnt_ff;
    logic [2:0]  idx_ff;
    logic [31:0] tmo_ff;
    logic        issued_ff;
    nfh_seq_t    st_ff;
    nfh_seq_t    nxt_st;

    logic        eng_idle;
    logic        eng_done;
    logic [15:0] eng_rdata;

    // ****************************************
    // bus slave decode
    // ****************************************
    wire [7:0] ap_adr   = haddr_i[7:0];
    wire       ap_take  = hsel_i & htrans_i[1] & hready_i;
    wire       ap_stall = ap_take & (((ap_adr == REG_CMD) & hwrite_i) | (ap_adr == REG_DATA));
    wire       dp_plain = dp_ff & dp_wr_ff & hready_ff;
    wire       wr_ctrl  = dp_plain & (dp_adr_ff == REG_CTRL);
    wire       wr_addr  = dp_plain & (dp_adr_ff == REG_ADDR);
    wire       wr_stat  = dp_plain & (dp_adr_ff == REG_STAT);
    wire       dp_cmd   = dp_ff & !hready_ff & dp_wr_ff & (dp_adr_ff == REG_CMD);
    wire       dp_data  = dp_ff & !hready_ff & (dp_adr_ff == REG_DATA);
    wire       seq_idle = (st_ff == S_IDLE);
    wire       wide     = ctrl_ff[CTRL_WIDE];  // RL13

    // ****************************************
    // command acceptance
    // ****************************************
    wire [7:0] cmd_in   = hwdata_i[7:0];
    wire [2:0] nad_in   = hwdata_i[CMD_NAD_LSB +: 3];
    wire       bad_busy = !rb_i & (cmd_in != STATUS_CMD);               // RL23
    wire       bad_addr = (cmd_in == STATUS_CMD) & (nad_in != 3'h0);   // RL8
    wire       cmd_try  = dp_cmd & seq_idle;
    wire       cmd_go   = cmd_try & !bad_busy & !bad_addr;
    // a word transfer waits until the flash reports ready
    wire       data_go  = dp_data & seq_idle & rb_i;                    // RL9

    wire [2:0] nad      = cmd_ff[CMD_NAD_LSB +: 3];
    wire       do_wait  = cmd_ff[CMD_WAIT_BIT];  // RL20 RL21
    wire [2:0] last_bt  = wide ? LAST_BEAT16 : LAST_BEAT8;
    wire       word_fin = (st_ff == S_DATA) & eng_done & (idx_ff == last_bt);
    wire       addr_fin = (st_ff == S_ADDR) & eng_done & (idx_ff == nad - 3'h1);
    wire       tmo_wb   = (st_ff == S_WLO) & (tmo_ff == 32'(WB_LIM_CYC - 1));
    wire       tmo_busy = (st_ff == S_WHI) & (tmo_ff == 32'(BUSY_LIMIT - 1));

    // ****************************************
    // byte engine request
    // ****************************************
    wire        eng_act  = (st_ff == S_CMD) | (st_ff == S_ADDR) | (st_ff == S_DATA);
    wire        eng_go   = eng_act & eng_idle & !issued_ff;
    wire        eng_cle  = (st_ff == S_CMD);                    // RL6
    wire        eng_ale  = (st_ff == S_ADDR);                   // RL3
    wire        eng_rd   = (st_ff == S_DATA) & rd_ff;
    // column byte leaves first, then row bytes in order
    wire [7:0]  adr_byte = addr_ff[{idx_ff[1:0], 3'b000} +: 8];   // RL7
    wire [15:0] wr_half  = wdata_ff[{idx_ff[0], 4'h0} +: 16];
    wire [7:0]  wr_byte  = wdata_ff[{idx_ff[1:0], 3'b000} +: 8];
    wire [15:0] eng_data = eng_cle ? {8'h00, cmd_ff[7:0]} :
                           eng_ale ? {8'h00, adr_byte} :
                           wide    ? wr_half : {8'h00, wr_byte};  // RL14
    // low lane arrives first, so shift in from the top
    wire [31:0] nxt_pack = wide ? {eng_rdata, pack_ff[31:16]}
                                : {eng_rdata[7:0], pack_ff[31:8]};
    wire [9:0]  cnt_step = wide ? 10'h002 : 10'h001;
    wire        cnt_full = (cnt_ff >= PAGE_BYTES);                // RL4

    wire [31:0] stat_val = {6'h00, cnt_ff, 10'h000, err_ff, rb_i, !seq_idle};
    wire [31:0] rd_val   = (ap_adr == REG_CTRL) ? {29'h0000_0000, ctrl_ff} :
                           (ap_adr == REG_CMD)  ? {20'h0_0000, cmd_ff} :
                           (ap_adr == REG_ADDR) ? addr_ff :
                           (ap_adr == REG_STAT) ? stat_val : 32'h0000_0000;
    wire [3:0]  err_set  = {cnt_full & eng_done & (st_ff == S_DATA),
                            tmo_busy,
                            cmd_try & bad_addr,
                            cmd_try & bad_busy};

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            S_IDLE: begin
                if (cmd_go) begin
                    nxt_st = S_CMD;
                end else if (data_go) begin
                    nxt_st = S_DATA;
                end
            end
            S_CMD: begin
                if (eng_done) begin
                    nxt_st = (nad != 3'h0) ? S_ADDR : (do_wait ? S_WLO : S_IDLE);  // RL8
                end
            end
            S_ADDR: begin
                if (addr_fin) begin
                    nxt_st = do_wait ? S_WLO : S_IDLE;
                end
            end
            S_WLO: begin
                if (!rb_i || tmo_wb) begin
                    nxt_st = S_WHI;
                end
            end
            S_WHI: begin
                if (rb_i || tmo_busy) begin
                    nxt_st = S_IDLE;                        // RL12
                end
            end
            S_DATA: begin
                if (word_fin) begin
                    nxt_st = S_IDLE;
                end
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= S_IDLE; idx_ff <= 3'h0; tmo_ff <= 32'h0000_0000; issued_ff <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            issued_ff <= eng_go | (issued_ff & !eng_done);
            if (nxt_st != st_ff) begin
                idx_ff <= 3'h0;
                tmo_ff <= 32'h0000_0000;
            end else begin
                idx_ff <= idx_ff + {2'b00, eng_done};
                tmo_ff <= tmo_ff + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // bus slave registers
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dp_ff <= 1'b0; dp_wr_ff <= 1'b0; dp_adr_ff <= 8'h00;
            hready_ff <= 1'b1; hresp_ff <= 1'b0; hrdata_ff <= 32'h0000_0000;
        end else begin
            if (ap_take) begin
                dp_ff     <= 1'b1;
                dp_wr_ff  <= hwrite_i;
                dp_adr_ff <= ap_adr;
            end else if (hready_ff) begin
                dp_ff <= 1'b0;
            end
            // cmd writes hold the bus until the sequencer is idle, data accesses until the whole word is done
            if (ap_stall) begin
                hready_ff <= 1'b0;
            end else if (cmd_try || word_fin) begin
                hready_ff <= 1'b1;
            end
            if (ap_take && !ap_stall) begin
                hrdata_ff <= rd_val;
            end else if (word_fin && rd_ff) begin
                hrdata_ff <= nxt_pack;                        // RL15
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_ff <= CTRL_RST; cmd_ff <= 12'h000; addr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000; pack_ff <= 32'h0000_0000; rd_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= hwdata_i[2:0];
            end
            if (wr_addr) begin
                addr_ff <= hwdata_i;                          // RL19
            end
            if (cmd_go) begin
                cmd_ff <= hwdata_i[11:0];
            end
            if (data_go) begin
                wdata_ff <= hwdata_i;
                rd_ff    <= !dp_wr_ff;
            end
            if ((st_ff == S_DATA) && eng_done && rd_ff) begin
                pack_ff <= nxt_pack;
            end
        end
    end

    // software clears with ones; a fresh event in the same cycle stays set
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_ff <= 4'h0; cnt_ff <= 10'h000;
        end else begin
            err_ff <= (err_ff & ~(wr_stat ? hwdata_i[5:2] : 4'h0)) | err_set;
            if (cmd_go) begin
                cnt_ff <= 10'h000;
            end else if ((st_ff == S_DATA) && eng_done && !cnt_full) begin
                cnt_ff <= cnt_ff + cnt_step;
            end
        end
    end

    // ****************************************
    // pin engine
    // ****************************************
    nfh_byte_phy u_phy (
        .clk_sys_i       (clk_sys_i),
        .nrst_i          (nrst_i),
        .go_i            (eng_go),
        .rd_i            (eng_rd),
        .cle_i           (eng_cle),
        .ale_i           (eng_ale),
        .ale_low_i       (ctrl_ff[CTRL_ALE_LOW]),
        .data_i          (eng_data),
        .ad_i            (ad_i),
        .ad_o            (ad_o),
        .ad_oe_o         (ad_oe_o),
        .we_n_o          (we_n_o),
        .read_strobe_n_o (read_strobe_n_o),
        .cle_o           (cle_o),
        .ale_o           (ale_o),
        .idle_o          (eng_idle),
        .done_o          (eng_done),
        .rdata_o         (eng_rdata)
    );

    // chip select is a plain software level; a deselected flash ignores the strobes
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ce_n_o <= 1'b1;
        end else begin
            ce_n_o <= !ctrl_ff[CTRL_CE];                      // RL1
        end
    end

    assign hreadyout_o = hready_ff;
    assign hresp_o     = hresp_ff;
    assign hrdata_o    = hrdata_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    wire ale_act = ale_o ^ ctrl_ff[CTRL_ALE_LOW];

    latch_excl_a: assert property (!(cle_o && ale_act)) // RL3
        else $error("both latch enables active");
    cmd_one_byte_a: assert property ($rose(cle_o) |-> ##1 !we_n_o ##1 we_n_o ##1 !cle_o) // RL6
        else $error("command is not one write pulse");
    column_first_a: assert property ( // RL7
        $fell(we_n_o) && ale_act && idx_ff == 3'h0 |-> ad_o[7:0] == addr_ff[7:0])
        else $error("column byte not first");
    row_byte_a: assert property ( // RL19
        $fell(we_n_o) && ale_act && idx_ff == 3'h1 |-> ad_o[7:0] == addr_ff[15:8])
        else $error("first row byte wrong");
    status_noaddr_a: assert property ( // RL8
        st_ff == S_CMD && nxt_st == S_ADDR |-> cmd_ff[7:0] != STATUS_CMD)
        else $error("read-status followed by address");
    busy_cmd_a: assert property (cmd_go |-> rb_i || cmd_in == STATUS_CMD) // RL23
        else $error("command issued while flash busy");
    data_ready_a: assert property (data_go |-> rb_i ##1 st_ff == S_DATA) // RL9
        else $error("data access while busy");
    ale_idle_a: assert property ( // RL16
        $past(eng_idle) && eng_idle && !$past(eng_go) |-> ale_o == $past(ctrl_ff[CTRL_ALE_LOW]))
        else $error("idle address latch level wrong");
    pack_top_a: assert property ( // RL14
        word_fin && rd_ff && !wide |=> hrdata_o[31:24] == eng_rdata[7:0])
        else $error("last byte not in top lane");
    cmd_pins_a: assert property ( // RL10
        $rose(cle_o) |-> ad_oe_o && ad_o[7:0] == cmd_ff[7:0])
        else $error("command byte not on bus");

    read_cmd_c: cover property (cmd_go && cmd_in == CMD_READ && hwdata_i[CMD_WAIT_BIT]);
    prog_cmd_c: cover property (cmd_go && cmd_in == CMD_PROG);
    erase_cfm_c: cover property (cmd_go && cmd_in == CMD_ERASE_CFM);
    word_read_c: cover property (word_fin && rd_ff);
endmodule // nfh_host_ctrl

// ==== pkg/nfh_pkg.sv ====
// nfh_pkg: shared constants and types of the nand flash host controller
package nfh_pkg;
    // ****************************************
    // register map (byte addresses, low 8 bits)
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD  = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // control fields
    localparam int CTRL_ALE_LOW = 0;
    localparam int CTRL_WIDE    = 1;
    localparam int CTRL_CE      = 2;
    // command fields
    localparam int CMD_NAD_LSB  = 8;
    localparam int CMD_WAIT_BIT = 11;

    // ****************************************
    // flash geometry and opcodes
    // ****************************************
    localparam logic [9:0] PAGE_BYTES    = 10'h210;  // 528
    localparam int         PAGES_PER_BLK = 32;
    localparam int         PAGE_FLD_W    = 5;
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_PROG      = 8'h80;
    localparam logic [7:0] CMD_ERASE     = 8'h60;
    localparam logic [7:0] CMD_ERASE_CFM = 8'hD0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS        = 50;
    localparam int RD_CYCLE_NS   = 50;
    localparam int STROBE_CYC    = (RD_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_TYP_NS   = 200_000;
    localparam int ERASE_TYP_NS  = 2_000_000;
    localparam int BUSY_LIM_CYC  = 2 * ERASE_TYP_NS / CLK_NS;
    localparam int WB_LIM_NS     = 800;
    localparam int WB_LIM_CYC    = WB_LIM_NS / CLK_NS;
    localparam logic [2:0] LAST_BEAT8  = 3'h3;
    localparam logic [2:0] LAST_BEAT16 = 3'h1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD  = 3'b001,
        S_ADDR = 3'b010,
        S_WLO  = 3'b011,
        S_WHI  = 3'b100,
        S_DATA = 3'b101
    } nfh_seq_t;

    typedef enum logic [1:0] {
        E_IDLE  = 2'b00,
        E_SETUP = 2'b01,
        E_LOW   = 2'b10,
        E_HOLD  = 2'b11
    } nfh_eng_t;
endpackage

// ==== logic/nfh_byte_phy.sv ====
// nfh_byte_phy: one strobed byte or halfword transfer on the flash pins
module nfh_byte_phy (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        go_i,
    input  wire logic        rd_i,
    input  wire logic        cle_i,
    input  wire logic        ale_i,
    input  wire logic        ale_low_i,
    input  wire logic [15:0] data_i,
    input  wire logic [15:0] ad_i,
    output logic      [15:0] ad_o,
    output logic             ad_oe_o,
    output logic             we_n_o,
    output logic             read_strobe_n_o,
    output logic             cle_o,
    output logic             ale_o,
    output logic             idle_o,
    output logic             done_o,
    output logic      [15:0] rdata_o
);
    import nfh_pkg::*;

    nfh_eng_t    st_ff;
    logic        rd_ff;

    assign idle_o = (st_ff == E_IDLE);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= E_IDLE; rd_ff <= 1'b0; ad_o <= 16'h0000; ad_oe_o <= 1'b0;
            we_n_o <= 1'b1; read_strobe_n_o <= 1'b1; cle_o <= 1'b0; ale_o <= 1'b0;
            done_o <= 1'b0; rdata_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            unique case (st_ff)
                E_IDLE: begin
                    ale_o <= ale_low_i;
                    if (go_i) begin
                        // the caller never raises both latch enables
                        cle_o   <= cle_i;               // RL3
                        ale_o   <= ale_i ^ ale_low_i;   // RL16
                        rd_ff   <= rd_i;
                        ad_o    <= data_i;
                        ad_oe_o <= !rd_i;
                        st_ff   <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    we_n_o          <= rd_ff;     // RL2
                    read_strobe_n_o <= !rd_ff;
                    st_ff           <= E_LOW;
                end
                E_LOW: begin
                    we_n_o          <= 1'b1;      // RL10
                    read_strobe_n_o <= 1'b1;
                    // sampled on the edge where the read strobe rises
                    if (rd_ff) begin
                        rdata_o <= ad_i;          // RL17
                    end
                    st_ff <= E_HOLD;
                end
                E_HOLD: begin
                    // data held one cycle past the write strobe's rise
                    ad_oe_o <= 1'b0;
                    cle_o   <= 1'b0;
                    ale_o   <= ale_low_i;
                    done_o  <= 1'b1;
                    st_ff   <= E_IDLE;
                end
            endcase
        end
    end

    read_capture_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL17
        $rose(read_strobe_n_o) |-> rdata_o == $past(ad_i))
        else $error("read data not taken at read strobe rise");
    strobe_width_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL2
        $fell(we_n_o) |-> ##1 we_n_o ##1 !ad_oe_o)
        else $error("write strobe or data hold wrong");
endmodule // nfh_byte_phy

// ==== sim/nfh_flash_model.sv ====
// nfh_flash_model: behavioural nand flash seen by the host controller
module nfh_flash_model #(
    parameter int         NROW   = 2,
    parameter int         T_RD   = 1000,
    parameter int         T_PROG = 2000,
    parameter int         T_ERS  = 4000,
    parameter logic [7:0] CFM    = 8'h10
) (
    input  wire logic       ce_n_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic [7:0] dq_i,
    output logic      [7:0] dq_o,
    output logic            dq_oe_o,
    output logic            rb_o,
    output logic      [7:0] last_cmd_o,
    output int              n_cmd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pg [0:527];
    logic [7:0] mem [int];
    logic [7:0] cmd;
    int         col, row, na, k;
    initial begin
        rb_o = 1'b1;
        dq_oe_o = 1'b0;
        dq_o = 8'h00;
        n_cmd_o = 0;
        last_cmd_o = 8'h00;
    end
    // short busy delays stand in for the typical array times
    task automatic go_busy(input int t);
        rb_o <= #50 1'b0;
        rb_o <= #(50 + t) 1'b1;
    endtask
    always @(posedge we_n_i) begin
        if (!ce_n_i && !(cle_i && ale_i)) begin
            if (cle_i) begin
                // confirm bytes act on the address latched before them
                if (dq_i != CFM && dq_i != 8'hD0) begin
                    na = 0;
                    row = 0;
                end
                cmd = dq_i;
                n_cmd_o++;
                last_cmd_o = dq_i;
                if (dq_i == 8'h80) for (int i = 0; i < 528; i++) pg[i] = 8'hFF;
                if (dq_i == CFM) begin
                    for (int i = 0; i < 528; i++) mem[row * 528 + i] = pg[i];
                    go_busy(T_PROG);
                end
                if (dq_i == 8'hD0) begin
                    for (int i = 0; i < 32 * 528; i++) mem.delete((row & ~31) * 528 + i);
                    go_busy(T_ERS);
                end
            end else if (ale_i) begin
                k = (cmd == 8'h60) ? na : na - 1;
                if (k < 0) col = dq_i;
                else row = row | (int'(dq_i) << (8 * k));
                na++;
                if (cmd == 8'h00 && na == NROW + 1) begin
                    for (int i = 0; i < 528; i++)
                        pg[i] = mem.exists(row * 528 + i) ? mem[row * 528 + i] : 8'hFF;
                    go_busy(T_RD);
                end
            end else begin
                pg[col % 528] = dq_i;
                col++;
            end
        end
    end
    always @(negedge re_n_i) if (!ce_n_i && !cle_i && !ale_i) begin
        dq_o = pg[col % 528];
        dq_oe_o = 1'b1;
    end
    always @(posedge re_n_i) begin
        col++;
        #20 dq_oe_o = 1'b0;
    end
    always @(posedge ce_n_i) dq_oe_o = 1'b0;
endmodule // nfh_flash_model

// ==== sim/nfh_host_ctrl_test.sv ====
// nfh_host_ctrl_test: self-checking bench of the nand flash host controller
module nfh_host_ctrl_test;
    import nfh_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, nrst, hsel, hwrite, hready, hresp, ce_n, cle, ale, we_n, re_n, ad_oe;
    logic        fl_oe, rb, alelow;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] ad_o, ad_bus, bus_q;
    logic [7:0]  fl_dq, last_cmd;
    int          n_cmd, num_errors, n_checks;
    // released lines toggle so a stale byte can never pass for a good one
    assign ad_bus = ad_oe ? ad_o : {~bus_q[15:8], fl_oe ? fl_dq : ~bus_q[7:0]};
    always @(posedge clk) bus_q <= ad_bus;
    initial begin
        clk = 0; nrst = 0; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0;
        bus_q = 0; alelow = 0; num_errors = 0; n_checks = 0;
    end
    always #25 clk = ~clk;
    nfh_host_ctrl #(.BUSY_LIMIT(200)) i_nfh_host_ctrl (.clk_sys_i(clk), .nrst_i(nrst),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale),
        .we_n_o(we_n), .read_strobe_n_o(re_n), .ad_o(ad_o), .ad_oe_o(ad_oe),
        .ad_i(ad_bus), .rb_i(rb));
    nfh_flash_model i_nfh_flash_model (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale ^ alelow),
        .we_n_i(we_n), .re_n_i(re_n), .dq_i(ad_bus[7:0]), .dq_o(fl_dq), .dq_oe_o(fl_oe),
        .rb_o(rb), .last_cmd_o(last_cmd), .n_cmd_o(n_cmd));
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // hready is looked at on the low phase, where it equals its value at the next rise
    task automatic wt(output logic [31:0] r);
        int n;
        n = 0;
        @(negedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 30000) begin
                num_errors++;
                end_sim;
            end
            @(negedge clk);
        end
        r = hrdata;
        @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        logic [31:0] x;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wt(x);
        htrans <= 2'b00;
        hwdata <= d;
        wt(r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r & m, e);
    endtask
    task automatic sync(input logic w);
        logic [31:0] r;
        int n;
        r = 32'h0000_0001;
        n = 0;
        while (r[0] || (w && !r[1])) begin
            n++;
            if (n > 300) begin
                num_errors++;
                end_sim;
            end
            bus(1'b0, REG_STAT, 32'h0000_0000, r);
        end
    endtask
    task automatic t_program_read(input logic [31:0] c, input logic [31:0] m,
                                  input logic [31:0] e);
        wr(REG_CTRL, c);
        wr(REG_ADDR, 32'h0000_2105);
        wr(REG_CMD, 32'h0000_0380);
        wr(REG_DATA, 32'hA1B2_C3D4);
        wr(REG_CMD, 32'h0000_0810);
        sync(1'b0);
        chk({24'h0, last_cmd}, 32'h0000_0010);
        wr(REG_CMD, 32'h0000_0B00);
        rd_chk(REG_DATA, m, e);
    endtask
    task automatic t_erase_busy;
        int n;
        wr(REG_ADDR, 32'h0000_0021);
        wr(REG_CMD, 32'h0000_0260);
        wr(REG_CMD, 32'h0000_00D0);
        sync(1'b0);
        n = n_cmd;
        wr(REG_CMD, 32'h0000_0000);
        sync(1'b0);
        chk(n_cmd, n);
        rd_chk(REG_STAT, 32'h0000_0004, 32'h0000_0004);
        wr(REG_CMD, 32'h0000_0170);
        rd_chk(REG_STAT, 32'h0000_0008, 32'h0000_0008);
        sync(1'b0);
        chk(n_cmd, n);
        wr(REG_STAT, 32'h0000_003C);
        wr(REG_CMD, 32'h0000_0070);
        sync(1'b0);
        chk({24'h0, last_cmd}, 32'h0000_0070);
        sync(1'b1);
        wr(REG_ADDR, 32'h0000_2105);
        wr(REG_CMD, 32'h0000_0B00);
        rd_chk(REG_DATA, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    endtask
    task automatic t_ctrl_pins;
        wr(REG_CTRL, 32'h0000_0005);
        alelow = 1'b1;
        repeat (2) @(posedge clk);
        chk(ale, 1'b1);
        wr(REG_CTRL, 32'h0000_0000);
        alelow = 1'b0;
        repeat (2) @(posedge clk);
        chk({ce_n, ale, ad_oe}, 3'b100);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        chk({hready, hresp, ce_n, we_n, re_n}, 5'b10111);
        nrst <= 1'b1;
        @(posedge clk);
        t_program_read(32'h0000_0004, 32'hFFFF_FFFF, 32'hA1B2_C3D4);
        t_erase_busy;
        t_program_read(32'h0000_0006, 32'h00FF_00FF, 32'h00B2_00D4);
        t_ctrl_pins;
        end_sim;
    end
endmodule // nfh_host_ctrl_test
